// ### rtl/aurw_defines.vh
// Register map, field positions, reset values and timing counts of the serial receiver
`ifndef AURW_DEFINES_VH
`define AURW_DEFINES_VH

// ****************************************
// Register word offsets (byte address = 4 x index)
// ****************************************
`define AURW_IDX_IRQ_FLAGS      4'h0
`define AURW_IDX_IRQ_ENABLES    4'h1
`define AURW_IDX_IRQ_PRIORITY   4'h2
`define AURW_IDX_RX_CTRL_STATUS 4'h3
`define AURW_IDX_RX_DATA        4'h4
`define AURW_IDX_TX_CTRL_STATUS 4'h5
`define AURW_IDX_BAUD_CONTROL   4'h6
`define AURW_IDX_DIV_HIGH       4'h7
`define AURW_IDX_DIV_LOW        4'h8
`define AURW_IDX_SLEEP          4'h9

// ****************************************
// Field positions
// ****************************************
`define AURW_BIT_RX_FLAG        5
`define AURW_BIT_PORT_EN        7
`define AURW_BIT_NINE_EN        6
`define AURW_BIT_CONT_EN        4
`define AURW_BIT_ADDR_EN        3
`define AURW_BIT_FRAME_ERR      2
`define AURW_BIT_OVERRUN        1
`define AURW_BIT_NINTH          0
`define AURW_BIT_SYNC_SEL       4
`define AURW_BIT_HIGH_SPEED     2
`define AURW_BIT_IDLE           6
`define AURW_BIT_GEN16          3
`define AURW_BIT_WAKE_EN        1

// ****************************************
// Reset values and timing
// ****************************************
`define AURW_RST_BYTE           8'h00
`define AURW_RST_TX_STATUS      8'h02
`define AURW_OVERSAMPLE         16
`define AURW_MID_SAMPLE         8

`endif

// ### rtl/aurw_receiver.v
// Asynchronous serial receiver with address detect and wake-up, Avalon-MM slave
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "aurw_defines.vh"

module aurw_receiver (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        receive_line_in,
  output reg         irq_high_out,
  output reg         irq_low_out
);

  // ****************************************
  // State encoding
  // ****************************************
  localparam ST_IDLE  = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA  = 2'd2;
  localparam ST_STOP  = 2'd3;

  // ****************************************
  // Registers
  // ****************************************
  // Software-visible control
  reg  [7:0]  irq_en_reg;
  reg  [7:0]  irq_pri_reg;
  reg  [7:0]  rx_ctrl_reg;
  reg  [7:0]  tx_ctrl_reg;
  reg  [7:0]  baud_ctrl_reg;
  reg  [7:0]  div_high_reg;
  reg  [7:0]  div_low_reg;
  reg         sleep_reg;

  // Receive status and buffer
  reg         rx_flag_reg;
  reg         frame_err_reg;
  reg         overrun_reg;
  reg         ninth_reg;
  reg  [7:0]  data_reg;

  // Frame recovery state
  reg  [1:0]  state_reg;
  reg  [15:0] baud_cnt_reg;
  reg  [5:0]  tick_cnt_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [8:0]  shift_reg;

  // Wake-up tracking
  reg         line_prev_reg;
  reg         woke_reg;

  // Mode and timing
  wire [7:0]  irq_flags;
  wire        async_on;
  wire        nine_on;
  wire        wake_on;
  wire [5:0]  ticks_per_bit;
  wire [15:0] divisor;
  wire        sample_tick;

  // Line edges
  wire        fall_edge;
  wire        rise_edge;

  // Bus decode
  wire        bus_req;
  wire        bus_done;
  wire        data_rd;
  wire        ctrl_wr;

  // Frame completion
  reg         char_done;
  reg         char_keep;

  // Offset decode shared by read and write paths
  function is_idx;
    input [3:0] addr;
    input [3:0] idx;
    begin
      is_idx = (addr == idx);
    end
  endfunction

  // Zero-extends an 8-bit register into the bus word
  function [31:0] byte_word;
    input [7:0] value;
    begin
      byte_word = {24'h000000, value};
    end
  endfunction

  // Mode decode
  assign async_on = rx_ctrl_reg[`AURW_BIT_PORT_EN] & ~tx_ctrl_reg[`AURW_BIT_SYNC_SEL];
  assign nine_on  = rx_ctrl_reg[`AURW_BIT_NINE_EN];
  assign wake_on  = baud_ctrl_reg[`AURW_BIT_WAKE_EN] & async_on;
  assign divisor  = baud_ctrl_reg[`AURW_BIT_GEN16] ? {div_high_reg, div_low_reg} : {8'h00, div_low_reg};
  // Sample clock per bit: sixty-four in low-speed 8-bit mode, else sixteen
  assign ticks_per_bit = (~baud_ctrl_reg[`AURW_BIT_GEN16] & ~tx_ctrl_reg[`AURW_BIT_HIGH_SPEED]) ?
                         6'd63 : 6'd15;
  assign sample_tick = (baud_cnt_reg == 16'h0000) & ~sleep_reg;
  assign fall_edge = line_prev_reg & ~receive_line_in;
  assign rise_edge = ~line_prev_reg & receive_line_in;
  // Request seen while waiting; completes at the next edge with wait low
  assign bus_req   = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  assign bus_done  = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
  assign data_rd   = bus_done & avs_read_in & is_idx(avs_address_in, `AURW_IDX_RX_DATA);
  assign ctrl_wr   = bus_done & avs_write_in & is_idx(avs_address_in, `AURW_IDX_RX_CTRL_STATUS);
  assign irq_flags = {2'b00, rx_flag_reg, 5'b00000};

  // ****************************************
  // Baud generator
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in || !async_on || sleep_reg || baud_cnt_reg == 16'h0000) begin
      baud_cnt_reg <= divisor;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 16'h0001;
    end
  end

  // ****************************************
  // Frame recovery
  // ****************************************
  always @* begin
    char_done = 1'b0;
    char_keep = 1'b0;
    if (state_reg == ST_STOP && sample_tick && tick_cnt_reg == ticks_per_bit) begin
      char_done = 1'b1;
      char_keep = ~(rx_ctrl_reg[`AURW_BIT_ADDR_EN] & nine_on) | shift_reg[8];
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg     <= ST_IDLE;
      tick_cnt_reg  <= 6'd0;
      bit_cnt_reg   <= 4'd0;
      shift_reg     <= 9'h000;
      line_prev_reg <= 1'b1;
    end else begin
      line_prev_reg <= receive_line_in;
      // Disabled, waking or asleep: hold the shifter idle
      if (!async_on || !rx_ctrl_reg[`AURW_BIT_CONT_EN] || wake_on || sleep_reg) begin
        state_reg <= ST_IDLE;
      end else if (sample_tick) begin
        // Oversample counter wraps once per bit time
        tick_cnt_reg <= (tick_cnt_reg == ticks_per_bit) ? 6'd0 : tick_cnt_reg + 6'd1;
        case (state_reg)
          // Wait for a low level that may be a start bit
          ST_IDLE: begin
            tick_cnt_reg <= 6'd0;
            if (!receive_line_in) begin
              state_reg <= ST_START;
            end
          end
          ST_START: begin
            // Mid-bit check rejects glitches
            if (tick_cnt_reg == {1'b0, ticks_per_bit[5:1]}) begin
              if (receive_line_in) begin
                state_reg <= ST_IDLE;
              end else begin
                tick_cnt_reg <= 6'd0;
                bit_cnt_reg  <= 4'd0;
                state_reg    <= ST_DATA;
              end
            end
          end
          // Sample each data bit at its middle
          ST_DATA: begin
            if (tick_cnt_reg == ticks_per_bit) begin
              // Shift in from the top, so first bit lands in bit 0
              if (nine_on) begin
                shift_reg <= {receive_line_in, shift_reg[8:1]};
              end else begin
                shift_reg <= {1'b0, receive_line_in, shift_reg[7:1]};
              end
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
              if (bit_cnt_reg == (nine_on ? 4'd8 : 4'd7)) begin
                state_reg <= ST_STOP;
              end
            end
          end
          // Stop bit sampled by the completion decode
          default: begin
            if (char_done) begin
              state_reg <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Status flags and wake-up
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_flag_reg   <= 1'b0;
      frame_err_reg <= 1'b0;
      overrun_reg   <= 1'b0;
      ninth_reg     <= 1'b0;
      data_reg      <= `AURW_RST_BYTE;
      woke_reg      <= 1'b0;
    end else begin
      // Read clears first; a same-cycle set below wins
      if (data_rd) begin
        rx_flag_reg <= 1'b0;
      end
      // Receive-enable low wipes the error bits
      if (!rx_ctrl_reg[`AURW_BIT_CONT_EN]) begin
        frame_err_reg <= 1'b0;
        overrun_reg   <= 1'b0;
      end
      // Completed character: load, or flag overrun if unread data waits
      if (char_done && char_keep) begin
        if (rx_flag_reg && !data_rd) begin
          overrun_reg <= 1'b1;
        end else begin
          data_reg      <= shift_reg[7:0];
          ninth_reg     <= shift_reg[8];
          frame_err_reg <= ~receive_line_in;
          rx_flag_reg   <= 1'b1;
        end
      end
      // Wake-up event arms once per enable
      if (!wake_on) begin
        woke_reg <= 1'b0;
      end else if (fall_edge && !woke_reg) begin
        woke_reg    <= 1'b1;
        rx_flag_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Avalon-MM slave, one wait state per access
  // ****************************************
  // Wait state and register writes
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      irq_en_reg          <= `AURW_RST_BYTE;
      irq_pri_reg         <= `AURW_RST_BYTE;
      rx_ctrl_reg         <= `AURW_RST_BYTE;
      tx_ctrl_reg         <= `AURW_RST_TX_STATUS;
      baud_ctrl_reg       <= `AURW_RST_BYTE;
      div_high_reg        <= `AURW_RST_BYTE;
      div_low_reg         <= `AURW_RST_BYTE;
      sleep_reg           <= 1'b0;
    end else begin
      // Wait drops for one cycle after a request is seen
      avs_waitrequest_out <= ~bus_req;
      // Wake-up ends on the first rising edge after the event
      if (wake_on && woke_reg && rise_edge) begin
        baud_ctrl_reg[`AURW_BIT_WAKE_EN] <= 1'b0;
      end
      // Writes commit only at the edge that completes the transfer
      if (bus_done && avs_write_in) begin
        // Interrupt enables
        if (is_idx(avs_address_in, `AURW_IDX_IRQ_ENABLES)) begin
          irq_en_reg <= avs_writedata_in[7:0];
        // Interrupt priorities
        end else if (is_idx(avs_address_in, `AURW_IDX_IRQ_PRIORITY)) begin
          irq_pri_reg <= avs_writedata_in[7:0];
        // Receive control; status bits are read-only
        end else if (ctrl_wr) begin
          rx_ctrl_reg <= {avs_writedata_in[7:3], 3'b000};
        // Transmit control; shifter-empty bit always reads one
        end else if (is_idx(avs_address_in, `AURW_IDX_TX_CTRL_STATUS)) begin
          tx_ctrl_reg <= {avs_writedata_in[7:2], 1'b1, avs_writedata_in[0]};
        // Baud control; idle bit is read-only
        end else if (is_idx(avs_address_in, `AURW_IDX_BAUD_CONTROL)) begin
          baud_ctrl_reg <= {2'b00, avs_writedata_in[5:3], 1'b0, avs_writedata_in[1:0]};
        // Divisor bytes
        end else if (is_idx(avs_address_in, `AURW_IDX_DIV_HIGH)) begin
          div_high_reg <= avs_writedata_in[7:0];
        end else if (is_idx(avs_address_in, `AURW_IDX_DIV_LOW)) begin
          div_low_reg <= avs_writedata_in[7:0];
        // Sleep control
        end else if (is_idx(avs_address_in, `AURW_IDX_SLEEP)) begin
          sleep_reg <= avs_writedata_in[0];
        end
      end
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  // Captured in the wait cycle so it stands at the completing edge
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (bus_req && avs_read_in) begin
      // Interrupt flag, enable and priority bytes
      if (is_idx(avs_address_in, `AURW_IDX_IRQ_FLAGS)) begin
        avs_readdata_out <= byte_word(irq_flags);
      end else if (is_idx(avs_address_in, `AURW_IDX_IRQ_ENABLES)) begin
        avs_readdata_out <= byte_word(irq_en_reg);
      end else if (is_idx(avs_address_in, `AURW_IDX_IRQ_PRIORITY)) begin
        avs_readdata_out <= byte_word(irq_pri_reg);
      // Receive control with error and ninth bits
      end else if (is_idx(avs_address_in, `AURW_IDX_RX_CTRL_STATUS)) begin
        avs_readdata_out <= byte_word({rx_ctrl_reg[7:3], frame_err_reg, overrun_reg, ninth_reg});
      // Received byte
      end else if (is_idx(avs_address_in, `AURW_IDX_RX_DATA)) begin
        avs_readdata_out <= byte_word(data_reg);
      end else if (is_idx(avs_address_in, `AURW_IDX_TX_CTRL_STATUS)) begin
        avs_readdata_out <= byte_word(tx_ctrl_reg);
      // Baud control with live idle status
      end else if (is_idx(avs_address_in, `AURW_IDX_BAUD_CONTROL)) begin
        avs_readdata_out <= byte_word({1'b0, state_reg == ST_IDLE, baud_ctrl_reg[5:0]});
      end else if (is_idx(avs_address_in, `AURW_IDX_DIV_HIGH)) begin
        avs_readdata_out <= byte_word(div_high_reg);
      end else if (is_idx(avs_address_in, `AURW_IDX_DIV_LOW)) begin
        avs_readdata_out <= byte_word(div_low_reg);
      end else if (is_idx(avs_address_in, `AURW_IDX_SLEEP)) begin
        avs_readdata_out <= byte_word({7'h00, sleep_reg});
      // Unmapped indices read zero
      end else begin
        avs_readdata_out <= 32'h00000000;
      end
    end
  end

  // ****************************************
  // Receive request by priority
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_high_out <= 1'b0;
      irq_low_out  <= 1'b0;
    end else begin
      irq_high_out <= rx_flag_reg & irq_en_reg[`AURW_BIT_RX_FLAG] & irq_pri_reg[`AURW_BIT_RX_FLAG];
      irq_low_out  <= rx_flag_reg & irq_en_reg[`AURW_BIT_RX_FLAG] & ~irq_pri_reg[`AURW_BIT_RX_FLAG];
    end
  end

endmodule

// ### test/aurw_remote_tx.sv
// Remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module aurw_remote_tx (
  input  wire clk_in,
  output reg  line_out
);
  // Idle line stands high
  initial line_out = 1'b1;
  // Hold one level for n clocks
  task automatic hold(input logic b, input int n);
    @(posedge clk_in);
    line_out <= b;
    repeat (n - 1) @(posedge clk_in);
  endtask
  // Start, data LSB first, stop, one idle bit
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bt);
    int i;
    hold(1'b0, bt);
    for (i = 0; i < nb; i++) begin
      hold(d[i], bt);
    end
    hold(stp, bt);
    hold(1'b1, bt);
  endtask
  // All-zero break, left low for the caller
  task automatic brk(input int bits, input int bt);
    hold(1'b0, bits * bt);
  endtask
endmodule

// ### test/aurw_rx_monitor.sv
// Bus handshake and interrupt checks for the serial receiver
`timescale 1ns/1ps
module aurw_rx_monitor (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire [3:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        receive_line_in,
  input wire        irq_high_out,
  input wire        irq_low_out
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire       req   = avs_read_in | avs_write_in;
  wire       rdone = avs_read_in & ~avs_waitrequest_out;
  wire       irq   = irq_high_out | irq_low_out;
  reg  [2:0] since_clr;
  // Cycles since the last data read or any write
  always @(posedge clk_in) begin
    if (!rst_n_in || (req && (avs_write_in || avs_address_in == 4'h4)))
      since_clr <= (rst_n_in ? 3'h0 : 3'h7);
    else if (since_clr != 3'h7)
      since_clr <= since_clr + 3'h1;
  end
  sequence s_req;
    req && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_one_wait: assert property (s_req |=> s_ack)
    else $error("access not answered after one wait state");
  a_idle_waits: assert property (!req |=> avs_waitrequest_out)
    else $error("wait released without a request");
  a_upper_zero: assert property (avs_readdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_data_moves: assert property ($changed(avs_readdata_out) |-> rdone)
    else $error("read data changed outside a read");
  a_unmapped_zero: assert property (rdone && avs_address_in > 4'h9 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_irq_single: assert property (!(irq_high_out && irq_low_out))
    else $error("both priority requests high");
  a_read_clears: assert property (rdone && avs_address_in == 4'h4 |-> ##[1:3] !irq)
    else $error("data read did not drop the request");
  a_irq_drop_cause: assert property ($fell(irq) |-> since_clr < 3'h5)
    else $error("request dropped without a read or write");
endmodule

// ### test/tb_top.sv
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
module tb_top;
  localparam int BT = 32;
  typedef struct {logic [7:0] ctl; logic [8:0] d; logic ld;} aurw_row_t;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  wire  [31:0] avs_readdata_out;
  wire         avs_waitrequest_out;
  wire         receive_line_in;
  wire         irq_high_out;
  wire         irq_low_out;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cycles = 0;
  int          i;
  logic [31:0] r;
  aurw_row_t   rows [7] = '{'{8'h90, 9'h0A5, 1'b1}, '{8'hD0, 9'h13C, 1'b1}, '{8'hD8, 9'h155, 1'b1},
    '{8'hD8, 9'h0AA, 1'b0}, '{8'hD0, 9'h0AA, 1'b1}, '{8'h80, 9'h0FF, 1'b0}, '{8'h10, 9'h0FF, 1'b0}};
  aurw_receiver dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .receive_line_in(receive_line_in), .irq_high_out(irq_high_out), .irq_low_out(irq_low_out));
  aurw_remote_tx tx (.clk_in(clk_in), .line_out(receive_line_in));
  // Clock and hang guard
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus access; read data lands in r
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_read_in <= ~w;
    avs_write_in <= w;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    r = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    bus(0, 4'h5, 8'h00);
    ck(r, 32'h02);
    bus(0, 4'h3, 8'h00);
    ck(r, 32'h00);
    bus(1, 4'h0, 8'hFF);
    bus(1, 4'hF, 8'hFF);
    bus(0, 4'h0, 8'h00);
    ck(r, 32'h00);
    bus(0, 4'hF, 8'h00);
    ck(r, 32'h00);
    bus(1, 4'h5, 8'h04);
    bus(1, 4'h8, 8'h01);
    bus(1, 4'h6, 8'h00);
    bus(1, 4'h1, 8'h20);
    for (i = 0; i < 7; i++) begin
      bus(1, 4'h2, {2'b0, i[0], 5'h0});
      bus(1, 4'h3, rows[i].ctl);
      tx.send(rows[i].d, rows[i].ctl[6] ? 9 : 8, 1'b1, BT);
      bus(0, 4'h0, 8'h00);
      ck(r, {26'h0, rows[i].ld, 5'h0});
      ck({30'h0, irq_high_out, irq_low_out}, {30'h0, rows[i].ld & i[0], rows[i].ld & ~i[0]});
      if (rows[i].ld) begin
        bus(0, 4'h3, 8'h00);
        ck(r, {24'h0, rows[i].ctl[7:1], rows[i].d[8]});
        bus(0, 4'h4, 8'h00);
        ck(r, {24'h0, rows[i].d[7:0]});
      end
    end
    // Overrun, then errors cleared by receive enable
    bus(1, 4'h3, 8'h90);
    tx.send(9'h011, 8, 1'b1, BT);
    tx.send(9'h022, 8, 1'b1, BT);
    bus(0, 4'h3, 8'h00);
    ck(r, 32'h92);
    bus(0, 4'h4, 8'h00);
    ck(r, 32'h11);
    bus(1, 4'h3, 8'h80);
    bus(0, 4'h3, 8'h00);
    ck(r, 32'h80);
    // Zero stop bit
    bus(1, 4'h3, 8'h90);
    tx.send(9'h033, 8, 1'b0, BT);
    bus(0, 4'h3, 8'h00);
    ck(r, 32'h94);
    bus(1, 4'h3, 8'h80);
    bus(0, 4'h3, 8'h00);
    ck(r, 32'h80);
    bus(0, 4'h4, 8'h00);
    ck(r, 32'h33);
    // Wake-up on a break
    bus(1, 4'h3, 8'h90);
    bus(1, 4'h6, 8'h02);
    tx.brk(12, BT);
    bus(0, 4'h0, 8'h00);
    ck(r, 32'h20);
    bus(0, 4'h6, 8'h00);
    ck(r & 32'h02, 32'h02);
    ck(r & 32'h40, 32'h40);
    tx.hold(1'b1, 4 * BT);
    bus(0, 4'h6, 8'h00);
    ck(r & 32'h02, 32'h00);
    bus(0, 4'h3, 8'h00);
    ck(r, 32'h90);
    bus(0, 4'h4, 8'h00);
    bus(0, 4'h0, 8'h00);
    ck(r, 32'h00);
    tx.send(9'h05A, 8, 1'b1, BT);
    bus(0, 4'h4, 8'h00);
    ck(r, 32'h5A);
    // Sleep blocks reception
    bus(1, 4'h9, 8'h01);
    tx.send(9'h077, 8, 1'b1, BT);
    bus(0, 4'h0, 8'h00);
    ck(r, 32'h00);
    bus(1, 4'h9, 8'h00);
    // Wake-up ignored in synchronous mode
    bus(1, 4'h5, 8'h14);
    bus(1, 4'h6, 8'h02);
    tx.brk(2, BT);
    tx.hold(1'b1, BT);
    bus(0, 4'h0, 8'h00);
    ck(r, 32'h00);
    bus(1, 4'h6, 8'h00);
    // Sixty-four times sampling, request masked
    bus(1, 4'h1, 8'h00);
    bus(1, 4'h5, 8'h00);
    tx.send(9'h0C3, 8, 1'b1, 4 * BT);
    ck({30'h0, irq_high_out, irq_low_out}, 32'h0);
    bus(0, 4'h4, 8'h00);
    ck(r, 32'hC3);
    print_verdict();
  end
endmodule
bind aurw_receiver aurw_rx_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .receive_line_in(receive_line_in),
  .irq_high_out(irq_high_out), .irq_low_out(irq_low_out));
